// ==== src/clock_ctl_pkg.sv ====
// Package for the clock divider and sleep control block.
// Assumes a single master clock and an APB register port on the same clock.
package clock_ctl_pkg;

  // Register byte offsets on the APB port
  localparam logic [7:0] ADDR_TRIM    = 8'h00;
  localparam logic [7:0] ADDR_DIVIDER = 8'h04;
  localparam logic [7:0] ADDR_CORE    = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;

  // Field positions
  localparam int UNLOCK_BIT = 7;
  localparam int ARM_BIT    = 5;
  localparam int MODE_MSB   = 4;
  localparam int MODE_LSB   = 3;
  localparam int SELECT_MSB = 3;

  // Values after reset, and the highest select code
  localparam logic [7:0]  TRIM_RESET     = 8'h00;
  localparam logic [3:0]  SEL_DIV1       = 4'h0;
  localparam logic [3:0]  SEL_DIV8       = 4'h3;
  localparam logic [3:0]  SEL_MAX        = 4'h8;
  localparam logic [7:0]  COUNT_RESET    = 8'h00;
  localparam logic [15:0] WAIT_RESET     = 16'h0000;

  // Cycle counts
  localparam logic [2:0]  UNLOCK_CYCLES       = 3'h4;
  localparam logic [15:0] WAKE_HALT_CYCLES    = 16'h0004;
  localparam logic [15:0] STANDBY_WAKE_CYCLES = 16'h0006;
  localparam logic [15:0] STANDBY_STARTUP     = STANDBY_WAKE_CYCLES - WAKE_HALT_CYCLES;

  // Sleep modes as held in the core control register
  typedef enum logic [1:0] {
    MODE_IDLE       = 2'h0,
    MODE_ADC_QUIET  = 2'h1,
    MODE_POWER_DOWN = 2'h2,
    MODE_STANDBY    = 2'h3
  } sleep_mode_t;

  // Sleep sequencer states, Gray coded along run, sleep, start-up, halt
  typedef enum logic [1:0] {
    ST_RUN     = 2'h0,
    ST_SLEEP   = 2'h1,
    ST_STARTUP = 2'h3,
    ST_HALT    = 2'h2
  } sleep_state_t;

  // Clock enables towards the clock tree; osc is a level, the rest pulses
  typedef struct packed {
    logic osc;
    logic adc;
    logic io;
    logic flash;
    logic cpu;
  } clock_gates_t;

  // Wake requests from the interrupt logic, same clock
  typedef struct packed {
    logic any_irq;
    logic adc_irq;
    logic mem_ready_irq;
    logic watchdog_irq;
    logic external_interrupt_zero_level_mode;
  } wake_irq_t;

endpackage

// ==== src/clock_divider_and_sleep_control.sv ====
// Clock divider, oscillator trim and sleep sequencer with an APB register port.
// Assumes pclk is the undivided master clock and straps are stable at reset.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module clock_divider_and_sleep_control #(
  parameter logic [15:0] POWERDOWN_STARTUP = 16'h0102
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [7:0]                  factory_trim,
  input  wire logic                        start_divide_by_eight_fuse,
  input  wire logic                        crystal_source,
  input  wire logic                        adc_enabled,
  input  wire logic                        sleep_instr,
  input  wire clock_ctl_pkg::wake_irq_t    wake_irq,
  input  wire logic                        external_interrupt_zero,
  input  wire logic                        pin_change,
  output logic      [7:0]                  oscillator_trim,
  output logic                             sys_clk_en,
  output clock_ctl_pkg::clock_gates_t      clk_en,
  output logic                             adc_start,
  output logic                             sleeping,
  output logic                             core_resume
);

  // Register state
  logic [7:0]                 next_oscillator_trim;
  logic                       sleep_arm;
  logic                       next_sleep_arm;
  clock_ctl_pkg::sleep_mode_t sleep_mode_select;
  clock_ctl_pkg::sleep_mode_t next_sleep_mode_select;
  logic                       straps_loaded;
  logic                       next_straps_loaded;
  logic [31:0]                next_prdata;
  logic                       next_pready;
  logic                       next_pslverr;
  logic                       bus_write;

  // Divider state
  logic                       divider_unlock;
  logic                       next_divider_unlock;
  logic [2:0]                 unlock_count;
  logic [2:0]                 next_unlock_count;
  logic [3:0]                 divider_select;
  logic [3:0]                 next_divider_select;
  logic [3:0]                 active_select;
  logic [3:0]                 next_active_select;
  logic [7:0]                 div_count;
  logic [7:0]                 next_div_count;
  logic                       next_sys_clk_en;

  // Sleep state
  clock_ctl_pkg::sleep_state_t state;
  clock_ctl_pkg::sleep_state_t next_state;
  clock_ctl_pkg::sleep_mode_t  active_mode;
  clock_ctl_pkg::sleep_mode_t  next_active_mode;
  logic [15:0]                 wait_count;
  logic [15:0]                 next_wait_count;
  logic                        next_adc_start;
  logic                        next_core_resume;
  logic                        next_sleeping;
  clock_ctl_pkg::clock_gates_t gates_on;
  clock_ctl_pkg::clock_gates_t next_clk_en;
  logic                        wake_hit;

  // Pin synchronisers
  logic [1:0]                  pin_meta;
  logic [1:0]                  pin_sync;

  // Divide limit for a select code; reserved codes run at the slowest rate
  function automatic logic [7:0] div_limit(input logic [3:0] sel);
    logic [8:0] full;
    full = 9'h000;
    if (sel > clock_ctl_pkg::SEL_MAX)
    begin
      full = 9'h100;
    end
    else
    begin
      full = 9'h001 << sel;
    end
    div_limit = 8'(full - 9'h001);
  endfunction

  // Start-up wait for the mode being left
  function automatic logic [15:0] startup_len(input clock_ctl_pkg::sleep_mode_t mode);
    logic [15:0] len;
    len = clock_ctl_pkg::WAIT_RESET;
    if (mode == clock_ctl_pkg::MODE_POWER_DOWN)
    begin
      len = POWERDOWN_STARTUP;
    end
    else if (mode == clock_ctl_pkg::MODE_STANDBY)
    begin
      len = clock_ctl_pkg::STANDBY_STARTUP;
    end
    startup_len = len;
  endfunction

  // Read data decode
  function automatic logic [31:0] read_reg(input logic [7:0] addr,
                                           input logic [7:0] trim,
                                           input logic [7:0] divider,
                                           input logic [7:0] core,
                                           input logic [7:0] status);
    logic [31:0] data;
    data = 32'h0000_0000;
    if (addr == clock_ctl_pkg::ADDR_TRIM)
    begin
      data = {24'h00_0000, trim};
    end
    else if (addr == clock_ctl_pkg::ADDR_DIVIDER)
    begin
      data = {24'h00_0000, divider};
    end
    else if (addr == clock_ctl_pkg::ADDR_CORE)
    begin
      data = {24'h00_0000, core};
    end
    else if (addr == clock_ctl_pkg::ADDR_STATUS)
    begin
      data = {24'h00_0000, status};
    end
    read_reg = data;
  endfunction

  // Two flip-flops on the asynchronous wake pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end
    else
    begin
      pin_meta <= {pin_change, external_interrupt_zero};
      pin_sync <= pin_meta;
    end
  end

  assign bus_write = psel && penable && pready && pwrite;

  // APB slave: one-cycle answer, trim and core control registers
  always_comb
  begin
    logic mapped;
    mapped                 = (paddr == clock_ctl_pkg::ADDR_TRIM) || (paddr == clock_ctl_pkg::ADDR_DIVIDER) ||
                             (paddr == clock_ctl_pkg::ADDR_CORE) || (paddr == clock_ctl_pkg::ADDR_STATUS);
    next_oscillator_trim   = oscillator_trim;
    next_sleep_arm         = sleep_arm;
    next_sleep_mode_select = sleep_mode_select;
    next_straps_loaded     = 1'b1;
    next_pready            = psel && !penable;
    next_pslverr           = psel && !penable && !mapped;
    next_prdata            = prdata;
    if (psel && !penable)
    begin
      next_prdata = read_reg(paddr, oscillator_trim,
                             {divider_unlock, 3'h0, divider_select},
                             {2'h0, sleep_arm, sleep_mode_select, 3'h0},
                             {active_select, active_mode, state});
    end
    if (!straps_loaded)
    begin
      next_oscillator_trim = factory_trim;
    end
    else if (bus_write && paddr == clock_ctl_pkg::ADDR_TRIM)
    begin
      next_oscillator_trim = pwdata[7:0];
    end
    if (bus_write && paddr == clock_ctl_pkg::ADDR_CORE)
    begin
      next_sleep_arm         = pwdata[clock_ctl_pkg::ARM_BIT];
      next_sleep_mode_select = clock_ctl_pkg::sleep_mode_t'(pwdata[clock_ctl_pkg::MODE_MSB:clock_ctl_pkg::MODE_LSB]);
    end
  end

  // Register and bus flip-flops; sleep never touches them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oscillator_trim   <= clock_ctl_pkg::TRIM_RESET;
      sleep_arm         <= 1'b0;
      sleep_mode_select <= clock_ctl_pkg::MODE_IDLE;
      straps_loaded     <= 1'b0;
      prdata            <= 32'h0000_0000;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
    end
    else
    begin
      oscillator_trim   <= next_oscillator_trim;
      sleep_arm         <= next_sleep_arm;
      sleep_mode_select <= next_sleep_mode_select;
      straps_loaded     <= next_straps_loaded;
      prdata            <= next_prdata;
      pready            <= next_pready;
      pslverr           <= next_pslverr;
    end
  end

  // Unlock window, select field and the master clock divider
  always_comb
  begin
    logic div_write;
    logic unlock_pattern;
    div_write           = bus_write && paddr == clock_ctl_pkg::ADDR_DIVIDER;
    unlock_pattern      = pwdata[7:0] == 8'h80;
    next_divider_unlock = divider_unlock;
    next_unlock_count   = unlock_count;
    next_divider_select = divider_select;
    next_active_select  = active_select;
    next_div_count      = div_count + 8'h01;
    next_sys_clk_en     = 1'b0;
    if (divider_unlock)
    begin
      next_unlock_count = unlock_count + 3'h1;
      if (next_unlock_count == clock_ctl_pkg::UNLOCK_CYCLES)
      begin
        next_divider_unlock = 1'b0;
      end
    end
    if (div_write)
    begin
      if (unlock_pattern && !divider_unlock)
      begin
        next_divider_unlock = 1'b1;
        next_unlock_count   = 3'h0;
      end
      else if (divider_unlock && !pwdata[clock_ctl_pkg::UNLOCK_BIT])
      begin
        next_divider_select = pwdata[clock_ctl_pkg::SELECT_MSB:0];
        next_divider_unlock = 1'b0;
      end
    end
    // Rewriting the unlock pattern while open falls through unchanged
    if (!straps_loaded)
    begin
      next_divider_select = start_divide_by_eight_fuse ? clock_ctl_pkg::SEL_DIV8 : clock_ctl_pkg::SEL_DIV1;
      next_active_select  = next_divider_select;
      next_div_count      = clock_ctl_pkg::COUNT_RESET;
    end
    else if (div_count >= div_limit(active_select))
    begin
      next_sys_clk_en    = 1'b1;
      next_div_count     = clock_ctl_pkg::COUNT_RESET;
      next_active_select = divider_select;
    end
  end

  // Divider flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      divider_unlock <= 1'b0;
      unlock_count   <= 3'h0;
      divider_select <= clock_ctl_pkg::SEL_DIV1;
      active_select  <= clock_ctl_pkg::SEL_DIV1;
      div_count      <= clock_ctl_pkg::COUNT_RESET;
      sys_clk_en     <= 1'b0;
    end
    else
    begin
      divider_unlock <= next_divider_unlock;
      unlock_count   <= next_unlock_count;
      divider_select <= next_divider_select;
      active_select  <= next_active_select;
      div_count      <= next_div_count;
      sys_clk_en     <= next_sys_clk_en;
    end
  end

  // Wake sources allowed in the mode in force
  always_comb
  begin
    logic ext_level;
    ext_level = (pin_sync[0] && wake_irq.external_interrupt_zero_level_mode) || pin_sync[1];
    wake_hit  = 1'b0;
    case (active_mode)
      clock_ctl_pkg::MODE_IDLE:
      begin
        wake_hit = wake_irq.any_irq || pin_sync[0] || pin_sync[1];
      end
      clock_ctl_pkg::MODE_ADC_QUIET:
      begin
        wake_hit = wake_irq.adc_irq || wake_irq.mem_ready_irq || wake_irq.watchdog_irq || ext_level;
      end
      default:
      begin
        wake_hit = wake_irq.watchdog_irq || ext_level;
      end
    endcase
  end

  // Sleep sequencer and clock gating
  always_comb
  begin
    next_state       = state;
    next_active_mode = active_mode;
    next_wait_count  = wait_count;
    next_adc_start   = 1'b0;
    next_core_resume = 1'b0;
    gates_on         = 5'b11111;
    case (state)
      clock_ctl_pkg::ST_RUN:
      begin
        if (sleep_instr && sleep_arm)
        begin
          next_state       = clock_ctl_pkg::ST_SLEEP;
          gates_on.cpu     = 1'b0;
          gates_on.flash   = 1'b0;
          next_active_mode = sleep_mode_select;
          if (sleep_mode_select == clock_ctl_pkg::MODE_STANDBY && !crystal_source)
          begin
            next_active_mode = clock_ctl_pkg::MODE_POWER_DOWN;
          end
          next_adc_start = adc_enabled && !sleep_mode_select[1];
        end
      end
      clock_ctl_pkg::ST_SLEEP:
      begin
        gates_on.cpu   = 1'b0;
        gates_on.flash = 1'b0;
        gates_on.io    = active_mode == clock_ctl_pkg::MODE_IDLE;
        gates_on.adc   = !active_mode[1];
        gates_on.osc   = active_mode != clock_ctl_pkg::MODE_POWER_DOWN;
        next_wait_count = clock_ctl_pkg::WAIT_RESET;
        if (wake_hit)
        begin
          next_state = (startup_len(active_mode) == clock_ctl_pkg::WAIT_RESET) ?
                       clock_ctl_pkg::ST_HALT : clock_ctl_pkg::ST_STARTUP;
        end
      end
      clock_ctl_pkg::ST_STARTUP:
      begin
        gates_on        = 5'b10000;
        next_wait_count = wait_count + 16'h0001;
        if (next_wait_count >= startup_len(active_mode))
        begin
          next_state      = clock_ctl_pkg::ST_HALT;
          next_wait_count = clock_ctl_pkg::WAIT_RESET;
        end
      end
      default:
      begin
        gates_on.cpu    = 1'b0;
        gates_on.flash  = 1'b0;
        next_wait_count = wait_count + 16'h0001;
        if (next_wait_count >= clock_ctl_pkg::WAKE_HALT_CYCLES)
        begin
          next_state       = clock_ctl_pkg::ST_RUN;
          next_wait_count  = clock_ctl_pkg::WAIT_RESET;
          next_core_resume = 1'b1;
        end
      end
    endcase
    next_sleeping   = next_state != clock_ctl_pkg::ST_RUN;
    next_clk_en     = gates_on & {1'b1, {4{next_sys_clk_en}}};
  end

  // Sequencer flip-flops; reset returns to run at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state       <= clock_ctl_pkg::ST_RUN;
      active_mode <= clock_ctl_pkg::MODE_IDLE;
      wait_count  <= clock_ctl_pkg::WAIT_RESET;
      adc_start   <= 1'b0;
      core_resume <= 1'b0;
      sleeping    <= 1'b0;
      clk_en      <= 5'b00000;
    end
    else
    begin
      state       <= next_state;
      active_mode <= next_active_mode;
      wait_count  <= next_wait_count;
      adc_start   <= next_adc_start;
      core_resume <= next_core_resume;
      sleeping    <= next_sleeping;
      clk_en      <= next_clk_en;
    end
  end

endmodule

`default_nettype wire

// ==== dv/clock_ctl_sva.sv ====
// Concurrent checks on the ports of the clock divider and sleep control block.
// Assumes one clock domain, pclk, with asynchronous active-low presetn.
`timescale 1ns/100ps
`default_nettype none
module clock_ctl_sva (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [7:0]                  factory_trim,
  input wire logic                        adc_enabled,
  input wire logic                        sleep_instr,
  input wire logic [7:0]                  oscillator_trim,
  input wire logic                        sys_clk_en,
  input wire clock_ctl_pkg::clock_gates_t clk_en,
  input wire logic                        adc_start,
  input wire logic                        sleeping,
  input wire logic                        core_resume
);
  logic [1:0] age;
  // Counts the first edges after reset so the strap load can be located
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_only_access: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_trim_load: assert property (age == 2'h1 |-> oscillator_trim == factory_trim)
    else $error("trim not loaded from strap");
  a_trim_write: assert property ($past(psel && penable && pready && pwrite && paddr == clock_ctl_pkg::ADDR_TRIM)
    |-> oscillator_trim == $past(pwdata[7:0]))
    else $error("trim write lost");
  a_trim_hold: assert property (age == 2'h3 && !$past(psel && penable && pready && pwrite)
    |-> $stable(oscillator_trim))
    else $error("trim changed without write");
  a_entry_cause: assert property ($rose(sleeping) |-> $past(sleep_instr))
    else $error("sleep without instruction");
  a_core_stopped: assert property (sleeping |-> !clk_en.cpu && !clk_en.flash)
    else $error("core clock runs in sleep");
  a_gates_aligned: assert property ((clk_en.cpu || clk_en.io || clk_en.adc || clk_en.flash)
    |-> sys_clk_en)
    else $error("gate pulse off divided clock");
  a_adc_in_sleep: assert property (adc_start |-> sleeping && adc_enabled)
    else $error("conversion start outside sleep");
  a_halt_before_run: assert property (core_resume |-> !sleeping && $past(sleeping) && $past(sleeping, 4))
    else $error("resume without halt");
  a_resume_pulse: assert property (core_resume |=> !core_resume)
    else $error("resume longer than one cycle");
endmodule
`default_nettype wire

// ==== dv/core_model.sv ====
// Model of the processor core side: issues the sleep instruction.
// Assumes the bench asks through exec_req; a halted core issues nothing.
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic exec_req,
  input  wire logic sleeping,
  output logic      sleep_instr
);
  // One-cycle sleep instruction, only while the core runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sleep_instr <= 1'b0;
    else
      sleep_instr <= exec_req && !sleeping && !sleep_instr;
  end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the clock divider and sleep control block.
// Assumes the package, design, checker and core model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]                  paddr = 8'h00, oscillator_trim, cv;
  logic [31:0]                 pwdata = 32'h0, prdata, rd;
  logic                        pready, pslverr, perr, sys_clk_en, adc_start, sleeping, core_resume;
  logic                        sleep_instr, exec_req = 1'b0, ext = 1'b0, pin = 1'b0, xtal = 1'b1, fuse = 1'b1;
  clock_ctl_pkg::wake_irq_t    wake_irq = '0;
  clock_ctl_pkg::clock_gates_t clk_en;
  logic [6:0]                  nowake [4] = '{7'h00, 7'h10, 7'h5c, 7'h1c};
  logic [6:0]                  waker  [4] = '{7'h20, 7'h08, 7'h41, 7'h02};
  int                          bad_count = 0, total_checks = 0, adc_cnt = 0, a0, k, p;
  always #25 pclk = ~pclk;
  clock_divider_and_sleep_control #(.POWERDOWN_STARTUP(16'h0004)) u_clock_divider_and_sleep_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .factory_trim(8'h5a),
    .start_divide_by_eight_fuse(fuse), .crystal_source(xtal), .adc_enabled(1'b1), .sleep_instr(sleep_instr),
    .wake_irq(wake_irq), .external_interrupt_zero(ext), .pin_change(pin), .oscillator_trim(oscillator_trim),
    .sys_clk_en(sys_clk_en), .clk_en(clk_en), .adc_start(adc_start), .sleeping(sleeping),
    .core_resume(core_resume));
  core_model u_core_model (.pclk(pclk), .presetn(presetn), .exec_req(exec_req), .sleeping(sleeping),
    .sleep_instr(sleep_instr));
  // Counts conversion starts
  always @(posedge pclk) if (adc_start === 1'b1) adc_cnt <= adc_cnt + 1;
  task automatic stop_test;
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask
  // One APB transfer: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) check("pready", 1'b0, 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic sleep_pulse;
    @(posedge pclk);
    exec_req <= 1'b1;
    @(posedge pclk);
    exec_req <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // Measures the steady spacing of divided clock pulses
  task automatic period;
    repeat (3)
    begin
      p = 0;
      do begin @(posedge pclk); p++; end while (sys_clk_en !== 1'b1 && p < 600);
    end
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc("trim reset", clock_ctl_pkg::ADDR_TRIM, 32'h5a);
    rdc("divider reset", clock_ctl_pkg::ADDR_DIVIDER, 32'h03);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", perr, 1'b1);
    check("unmapped data", rd, 32'h0);
    // Trim moves by at most 0x20 a step; no memory write runs meanwhile
    wr(clock_ctl_pkg::ADDR_TRIM, 8'h7a);
    wr(clock_ctl_pkg::ADDR_TRIM, 8'h7f);
    rdc("trim top low range", clock_ctl_pkg::ADDR_TRIM, 32'h7f);
    wr(clock_ctl_pkg::ADDR_TRIM, 8'h80);
    @(negedge pclk);
    check("trim out", oscillator_trim, 8'h80);
    wr(clock_ctl_pkg::ADDR_DIVIDER, 8'h81);
    rdc("unlock refused", clock_ctl_pkg::ADDR_DIVIDER, 32'h03);
    wr(clock_ctl_pkg::ADDR_DIVIDER, 8'h80);
    rdc("unlock open", clock_ctl_pkg::ADDR_DIVIDER, 32'h83);
    wr(clock_ctl_pkg::ADDR_DIVIDER, 8'h05);
    rdc("unlock timed out", clock_ctl_pkg::ADDR_DIVIDER, 32'h03);
    wr(clock_ctl_pkg::ADDR_DIVIDER, 8'h80);
    wr(clock_ctl_pkg::ADDR_DIVIDER, 8'h80);
    wr(clock_ctl_pkg::ADDR_DIVIDER, 8'h05);
    rdc("no restart", clock_ctl_pkg::ADDR_DIVIDER, 32'h03);
    // Select codes 0 to 9, reserved bits written high, no wake source active
    for (int c = 0; c < 10; c++)
    begin
      wr(clock_ctl_pkg::ADDR_DIVIDER, 8'h80);
      wr(clock_ctl_pkg::ADDR_DIVIDER, {4'h7, 4'(c)});
      rdc("select", clock_ctl_pkg::ADDR_DIVIDER, c);
      period();
      check("divide", p, (c > 8) ? 256 : (1 << c));
    end
    wr(clock_ctl_pkg::ADDR_DIVIDER, 8'h80);
    wr(clock_ctl_pkg::ADDR_DIVIDER, 8'h00);
    wr(clock_ctl_pkg::ADDR_CORE, 8'h00);
    sleep_pulse();
    check("unarmed", sleeping, 1'b0);
    // Each sleep mode: a source that must not wake (none driven in idle), then one that must
    for (int m = 0; m < 4; m++)
    begin
      a0 = adc_cnt;
      cv = {3'b001, 2'(m), 3'b000};
      wr(clock_ctl_pkg::ADDR_CORE, cv);
      sleep_pulse();
      check("asleep", sleeping, 1'b1);
      check("osc", clk_en.osc, m != 2);
      check("adc start", adc_cnt - a0, m < 2);
      {ext, pin, wake_irq} <= nowake[m];
      repeat (12) @(posedge pclk);
      check("no wake", sleeping, 1'b1);
      if (m > 0) check("io stopped", clk_en.io, 1'b0);
      {ext, pin, wake_irq} <= waker[m];
      k = 0;
      do begin @(posedge pclk); k++; end while (core_resume !== 1'b1 && k < 100);
      {ext, pin, wake_irq} <= 7'h00;
      check("woke", k < 100, 1'b1);
      if (m == 3) check("standby wake", k >= 5 && k <= 8, 1'b1);
      rdc("core kept", clock_ctl_pkg::ADDR_CORE, cv);
    end
    // Standby asked for without a crystal runs as power-down
    xtal <= 1'b0;
    wr(clock_ctl_pkg::ADDR_CORE, 8'h38);
    sleep_pulse();
    check("no crystal osc", clk_en.osc, 1'b0);
    {ext, pin, wake_irq} <= 7'h02;
    k = 0;
    do begin @(posedge pclk); k++; end while (core_resume !== 1'b1 && k < 100);
    {ext, pin, wake_irq} <= 7'h00;
    check("no crystal wake", k > 8 && k < 100, 1'b1);
    // Reset in power-down, fuse now unprogrammed
    wr(clock_ctl_pkg::ADDR_CORE, 8'h30);
    sleep_pulse();
    fuse <= 1'b0;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check("reset wakes", sleeping, 1'b0);
    check("trim reloaded", oscillator_trim, 8'h5a);
    rdc("core reset", clock_ctl_pkg::ADDR_CORE, 32'h0);
    rdc("divider fuse off", clock_ctl_pkg::ADDR_DIVIDER, 32'h00);
    stop_test();
  end
  // Cuts a hang short
  initial
  begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    stop_test();
  end
endmodule
bind clock_divider_and_sleep_control clock_ctl_sva u_clock_ctl_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .factory_trim, .adc_enabled, .sleep_instr, .oscillator_trim, .sys_clk_en,
  .clk_en, .adc_start, .sleeping, .core_resume);
`default_nettype wire
